// ==== logic/clk_ctrl_defines.svh ====
/*
 Offsets, field positions, fuse encodings and timing counts for the clock
 source and start-up controller. Assumes inclusion by bare name.
*/
`ifndef CLK_CTRL_DEFINES_SVH
`define CLK_CTRL_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define OFS_PLL_CSR      4'h0
`define OFS_OSC_CAL      4'h4
`define OFS_STATUS       4'h8

// ----------------------------------------------------------------------
// Field positions in the PLL control/status register
// ----------------------------------------------------------------------
`define BIT_PLL_LOCKED   0
`define BIT_PLL_ENABLE   1
`define BIT_PLL_LOW_SPD  2

// ----------------------------------------------------------------------
// Fuse encodings
// ----------------------------------------------------------------------
`define FUSE_SRC_PLL     4'h1
`define FUSE_SRC_RC8M    4'h2
`define FUSE_SRC_RC128K  4'h3
`define FUSE_SRC_LFXTAL  4'h4

// ----------------------------------------------------------------------
// Timing counts in source clock cycles; WDT_ counts in watchdog ticks
// ----------------------------------------------------------------------
`define CYC_14CK         16'h000E
`define CYC_6CK          16'h0006
`define CYC_1K           16'h0400
`define CYC_16K          16'h4000
`define CYC_32K          16'h8000
`define WDT_4MS          16'h0200
`define WDT_64MS         16'h2000
`define PLL_LOCK_CYC     8'h40

`endif

// ==== logic/clk_ctrl_pkg.sv ====
/*
 Types for the clock source and start-up controller.
 Assumes nothing of its surroundings.
*/
package clk_ctrl_pkg;

   // Start-up sequencer phases
   typedef enum logic [2:0]
   {
      ST_IDLE,
      ST_OSC_COUNT,
      ST_WDT_COUNT,
      ST_RUN,
      ST_SLEEP
   } startup_e;

   // Selected clock source
   typedef enum logic [2:0]
   {
      SRC_NONE,
      SRC_PLL,
      SRC_RC8M,
      SRC_RC128K,
      SRC_LFXTAL
   } source_e;

endpackage : clk_ctrl_pkg

// ==== logic/clock_source_pll_startup.sv ====
/*
 Clock source selection, PLL control and start-up delay sequencing.
 Registers reached over Avalon-MM with waitrequest. Source clocks and the
 watchdog oscillator arrive as one-cycle tick enables synchronous to clk_in.
*/
`timescale 1ns/1ps
`include "clk_ctrl_defines.svh"

module clock_source_pll_startup
   import clk_ctrl_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic [3:0]  clock_select_fuses_in,
   input  wire logic [1:0]  startup_time_fuses_in,
   input  wire logic        divide_by_eight_fuse_n_in,
   input  wire logic        reset_pin_disable_fuse_n_in,
   input  wire logic [7:0]  factory_cal_in,
   input  wire logic        power_on_reset_in,
   input  wire logic        deep_sleep_in,
   input  wire logic        wake_in,
   input  wire logic        src_tick_in,
   input  wire logic        wdt_tick_in,
   input  wire logic [3:0]  avs_address_in,
   input  wire logic        avs_read_in,
   input  wire logic        avs_write_in,
   input  wire logic [31:0] avs_writedata_in,
   output logic [31:0]      avs_readdata_out,
   output logic             avs_waitrequest_out,
   output logic             pll_run_out,
   output logic             rc_osc_run_out,
   output logic             pll_half_ref_out,
   output logic [7:0]       osc_calibration_out,
   output logic [2:0]       sys_source_out,
   output logic [1:0]       sys_div_log2_out,
   output logic             fast_timer_clk_ok_out,
   output logic             cpu_run_out,
   output logic             reserved_setting_out
);

   // ------------------------------------------------------------------
   // Source decode
   // ------------------------------------------------------------------
   source_e     src;
   logic        pll_is_sys;
   logic        reserved_sel;

   // Fuses read as programmed-low; decode is combinational on live straps
   always_comb
   begin
      case (clock_select_fuses_in)
         `FUSE_SRC_PLL:    src = SRC_PLL;
         `FUSE_SRC_RC8M:   src = SRC_RC8M;
         `FUSE_SRC_RC128K: src = SRC_RC128K;
         default:
         begin
            // Upper two fuse bits 01 select the watch crystal
            if (clock_select_fuses_in[3:2] == 2'b01)
               src = SRC_LFXTAL;
            else
               src = SRC_NONE;
         end
      endcase
   end

   assign pll_is_sys   = (src == SRC_PLL);
   assign reserved_sel = (startup_time_fuses_in == 2'b11) &&
                         (src != SRC_PLL);

   // ------------------------------------------------------------------
   // Start-up count selection
   // ------------------------------------------------------------------
   logic [15:0] osc_cycles;
   logic [15:0] wdt_cycles;
   logic [15:0] wake_cycles;

   // Cycle counts on the selected source, reset path and wake path
   always_comb
   begin
      osc_cycles  = `CYC_14CK;
      wdt_cycles  = 16'h0000;
      wake_cycles = `CYC_6CK;
      case (src)
         SRC_PLL:
         begin
            // PLL adds oscillator cycles plus a fixed 4 ms
            osc_cycles = startup_time_fuses_in[0] ?
                         16'(`CYC_14CK + `CYC_16K) :
                         16'(`CYC_14CK + `CYC_1K);
            wdt_cycles = `WDT_4MS;
            wake_cycles = osc_cycles;
         end
         SRC_RC8M, SRC_RC128K:
         begin
            case (startup_time_fuses_in)
               2'b00:
                  wdt_cycles = reset_pin_disable_fuse_n_in ?
                               16'h0000 : `WDT_4MS;
               2'b01:   wdt_cycles = `WDT_4MS;
               2'b10:   wdt_cycles = `WDT_64MS;
               default: wdt_cycles = 16'h0000;
            endcase
         end
         SRC_LFXTAL:
         begin
            osc_cycles  = (startup_time_fuses_in == 2'b10) ?
                          `CYC_32K : `CYC_1K;
            wake_cycles = osc_cycles;
            wdt_cycles  = (startup_time_fuses_in == 2'b00) ?
                          `WDT_4MS : `WDT_64MS;
         end
         default: wake_cycles = `CYC_6CK;
      endcase
   end

   // ------------------------------------------------------------------
   // Start-up sequencer
   // ------------------------------------------------------------------
   startup_e    state_ff;
   startup_e    nxt_state;
   logic [15:0] count_ff;
   logic [15:0] nxt_count;
   logic [15:0] wdt_target_ff;
   logic        cold_ff;

   // Oscillator count first, then watchdog-timed delay on cold start
   always_comb
   begin
      nxt_state = state_ff;
      nxt_count = count_ff;
      case (state_ff)
         ST_IDLE:
         begin
            if (!reserved_sel)
            begin
               nxt_state = ST_OSC_COUNT;
               nxt_count = 16'h0000;
            end
         end
         ST_OSC_COUNT:
         begin
            if (src_tick_in)
               nxt_count = 16'(count_ff + 16'h0001);
            // Wake uses the short count except on PLL and crystal, reset the full count
            if ((cold_ff && count_ff >= osc_cycles) ||
                (!cold_ff && count_ff >= wake_cycles))
            begin
               nxt_count = 16'h0000;
               nxt_state = (cold_ff || pll_is_sys) ?
                           ST_WDT_COUNT : ST_RUN;
            end
         end
         ST_WDT_COUNT:
         begin
            if (wdt_tick_in)
               nxt_count = 16'(count_ff + 16'h0001);
            if (count_ff >= wdt_target_ff)
               nxt_state = ST_RUN;
         end
         ST_RUN:
         begin
            if (deep_sleep_in)
               nxt_state = ST_SLEEP;
         end
         ST_SLEEP:
         begin
            if (wake_in)
            begin
               nxt_state = ST_OSC_COUNT;
               nxt_count = 16'h0000;
            end
         end
         default: nxt_state = ST_IDLE;
      endcase
      if (power_on_reset_in)
      begin
         nxt_state = ST_IDLE;
         nxt_count = 16'h0000;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         state_ff <= ST_IDLE;
         count_ff <= 16'h0000;
      end
      else
      begin
         state_ff <= nxt_state;
         count_ff <= nxt_count;
      end
   end

   // Cold flag and delay target latched when a reset start begins
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         cold_ff       <= 1'b1;
         wdt_target_ff <= 16'h0000;
      end
      else if (state_ff == ST_IDLE)
      begin
         cold_ff       <= 1'b1;
         wdt_target_ff <= wdt_cycles;
      end
      else if (state_ff == ST_SLEEP)
      begin
         // PLL wake also waits out its 4 or 64 ms share
         cold_ff       <= 1'b0;
         wdt_target_ff <= !pll_is_sys ? 16'h0000 :
                          startup_time_fuses_in[1] ? `WDT_64MS : `WDT_4MS;
      end
   end

   // ------------------------------------------------------------------
   // Software registers
   // ------------------------------------------------------------------
   logic        pll_enable_bit_ff;
   logic        pll_low_speed_bit_ff;
   logic        pll_locked_flag_ff;
   logic [7:0]  osc_calibration_reg_ff;
   logic [7:0]  lock_cnt_ff;
   logic        pll_on;
   logic        wr_csr;
   logic        wr_cal;

   assign wr_csr = avs_write_in && !avs_waitrequest_out &&
                   (avs_address_in == `OFS_PLL_CSR);
   assign wr_cal = avs_write_in && !avs_waitrequest_out &&
                   (avs_address_in == `OFS_OSC_CAL);

   // PLL control bits; low-speed cannot be raised under PLL system clock
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         pll_enable_bit_ff    <= 1'b0;
         pll_low_speed_bit_ff <= 1'b0;
      end
      else if (wr_csr)
      begin
         pll_enable_bit_ff <= avs_writedata_in[`BIT_PLL_ENABLE];
         if (!(pll_is_sys && avs_writedata_in[`BIT_PLL_LOW_SPD]))
            pll_low_speed_bit_ff <=
               avs_writedata_in[`BIT_PLL_LOW_SPD];
      end
   end

   // Factory byte loaded while the sequencer sits in ST_IDLE; software may retune
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
         osc_calibration_reg_ff <= 8'h00;
      else if (state_ff == ST_IDLE)
         osc_calibration_reg_ff <= factory_cal_in;
      else if (wr_cal)
         osc_calibration_reg_ff <= avs_writedata_in[7:0];
   end

   // PLL needs its fuse and bit, and halts in the deep sleep modes
   assign pll_on = (clock_select_fuses_in == `FUSE_SRC_PLL) &&
                   pll_enable_bit_ff &&
                   (state_ff != ST_SLEEP) && !deep_sleep_in;

   // Lock timer on reference ticks; any change of reference drops lock
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         lock_cnt_ff        <= 8'h00;
         pll_locked_flag_ff <= 1'b0;
      end
      else if (!pll_on || wr_cal ||
               (wr_csr && avs_writedata_in[`BIT_PLL_LOW_SPD] !=
                pll_low_speed_bit_ff && !pll_is_sys))
      begin
         lock_cnt_ff        <= 8'h00;
         pll_locked_flag_ff <= 1'b0;
      end
      else if (lock_cnt_ff >= `PLL_LOCK_CYC)
         pll_locked_flag_ff <= 1'b1;
      else if (src_tick_in)
         lock_cnt_ff <= 8'(lock_cnt_ff + 8'h01);
   end

   // ------------------------------------------------------------------
   // Avalon-MM slave: one wait state on every access
   // ------------------------------------------------------------------
   logic        ack_ff;

   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
         ack_ff <= 1'b0;
      else
         ack_ff <= (avs_read_in || avs_write_in) && !ack_ff;
   end

   // Waitrequest low in the cycle after the request appears
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
         avs_waitrequest_out <= 1'b1;
      else
         avs_waitrequest_out <= !((avs_read_in || avs_write_in) && !ack_ff);
   end

   // Read data registered alongside the acknowledge; unmapped reads zero
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
         avs_readdata_out <= 32'h0000_0000;
      else if (avs_read_in && !ack_ff)
      begin
         case (avs_address_in)
            `OFS_PLL_CSR:
               avs_readdata_out <= {29'h0000_0000, pll_low_speed_bit_ff,
                                    pll_enable_bit_ff, pll_locked_flag_ff};
            `OFS_OSC_CAL:
               avs_readdata_out <= {24'h00_0000, osc_calibration_reg_ff};
            `OFS_STATUS:
               avs_readdata_out <= {24'h00_0000, 2'b00, cpu_run_out,
                                    reserved_setting_out, 1'b0,
                                    sys_source_out};
            default:
               avs_readdata_out <= 32'h0000_0000;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Registered clock-tree controls
   // ------------------------------------------------------------------
   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         pll_run_out           <= 1'b0;
         rc_osc_run_out        <= 1'b0;
         pll_half_ref_out      <= 1'b0;
         osc_calibration_out   <= 8'h00;
         sys_source_out        <= 3'h0;
         sys_div_log2_out      <= 2'h0;
         fast_timer_clk_ok_out <= 1'b0;
         cpu_run_out           <= 1'b0;
         reserved_setting_out  <= 1'b0;
      end
      else
      begin
         // PLL as system clock also keeps it running
         pll_run_out <= pll_on || (pll_is_sys && state_ff != ST_SLEEP &&
                                   !deep_sleep_in);
         rc_osc_run_out <= (state_ff != ST_SLEEP) && !deep_sleep_in;
         // Halved reference gives 32 MHz from the x8 multiplier
         pll_half_ref_out    <= pll_low_speed_bit_ff;
         osc_calibration_out <= osc_calibration_reg_ff;
         sys_source_out      <= 3'(src);
         // Log2 divide: 2 for PLL/4, 3 for the fuse divide by eight
         if (!divide_by_eight_fuse_n_in)
            sys_div_log2_out <= 2'h3;
         else if (pll_is_sys)
            sys_div_log2_out <= 2'h2;
         else
            sys_div_log2_out <= 2'h0;
         fast_timer_clk_ok_out <= pll_locked_flag_ff;
         cpu_run_out           <= (state_ff == ST_RUN);
         reserved_setting_out  <= reserved_sel;
      end
   end

endmodule : clock_source_pll_startup

// ==== tb/clk_ctrl_checker_assertions.sv ====
/*
 Concurrent checks on the ports of the clock source and start-up block.
 Assumes one clock domain, synchronous active-low reset, bound below.
*/
`timescale 1ns/1ps

module clk_ctrl_checker
(
   input wire logic       clk_in,
   input wire logic       rst_n_in,
   input wire logic [3:0] clock_select_fuses_in,
   input wire logic       divide_by_eight_fuse_n_in,
   input wire logic [7:0] factory_cal_in,
   input wire logic       deep_sleep_in,
   input wire logic       avs_read_in,
   input wire logic       avs_write_in,
   input wire logic       avs_waitrequest_out,
   input wire logic       pll_run_out,
   input wire logic       rc_osc_run_out,
   input wire logic       pll_half_ref_out,
   input wire logic [7:0] osc_calibration_out,
   input wire logic [2:0] sys_source_out,
   input wire logic [1:0] sys_div_log2_out,
   input wire logic       fast_timer_clk_ok_out,
   input wire logic       cpu_run_out,
   input wire logic       reserved_setting_out
);
   // ------------------------------------------------------------------
   // Common clock and reset for all properties
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   // Bus answers one cycle after a fresh request, for one cycle only
   bus_answer_a: assert property ($rose(avs_read_in || avs_write_in)
      |=> !avs_waitrequest_out) else $error("bus answer late");
   bus_pulse_a: assert property (!avs_waitrequest_out
      |=> avs_waitrequest_out) else $error("waitrequest low too long");
   // PLL never runs outside the PLL fuse setting
   pll_gate_a: assert property (pll_run_out
      |-> clock_select_fuses_in == 4'h1) else $error("pll runs");
   // Sleep held three cycles must have both sources stopped
   sleep_stop_a: assert property (deep_sleep_in [*3]
      |-> !pll_run_out && !rc_osc_run_out)
      else $error("source runs in sleep");
   low_speed_a: assert property ($rose(pll_half_ref_out)
      |-> clock_select_fuses_in != 4'h1) else $error("low speed set");
   pll_sys_a: assert property (cpu_run_out && divide_by_eight_fuse_n_in
      && clock_select_fuses_in == 4'h1 |-> sys_source_out == 3'h1
      && sys_div_log2_out == 2'h2) else $error("pll div wrong");
   rc_sys_a: assert property (cpu_run_out
      && clock_select_fuses_in == 4'h2 |-> sys_source_out == 3'h2)
      else $error("rc source wrong");
   div_eight_a: assert property (cpu_run_out
      && !divide_by_eight_fuse_n_in |-> sys_div_log2_out == 2'h3)
      else $error("div8 wrong");
   // Calibration byte must be in place two edges after release
   cal_load_a: assert property ($rose(rst_n_in)
      |-> ##2 osc_calibration_out == factory_cal_in)
      else $error("calibration not loaded");
   // Fast timer clock good only after the PLL has been running
   timer_ok_a: assert property (fast_timer_clk_ok_out
      |-> $past(pll_run_out, 2)) else $error("timer clock without pll");
   reserved_a: assert property (reserved_setting_out
      |-> !cpu_run_out) else $error("run with reserved setting");
endmodule : clk_ctrl_checker

bind clock_source_pll_startup clk_ctrl_checker i_clk_ctrl_checker
(
   .clk_in(clk_in), .rst_n_in(rst_n_in),
   .clock_select_fuses_in(clock_select_fuses_in),
   .divide_by_eight_fuse_n_in(divide_by_eight_fuse_n_in),
   .factory_cal_in(factory_cal_in), .deep_sleep_in(deep_sleep_in),
   .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
   .avs_waitrequest_out(avs_waitrequest_out), .pll_run_out(pll_run_out),
   .rc_osc_run_out(rc_osc_run_out), .pll_half_ref_out(pll_half_ref_out),
   .osc_calibration_out(osc_calibration_out),
   .sys_source_out(sys_source_out), .sys_div_log2_out(sys_div_log2_out),
   .fast_timer_clk_ok_out(fast_timer_clk_ok_out),
   .cpu_run_out(cpu_run_out), .reserved_setting_out(reserved_setting_out)
);

// ==== tb/clock_source_pll_startup_tb.sv ====
/*
 Self-checking bench for the clock source and start-up block.
 Assumes the checker is bound in; ticks are driven every cycle to shorten, save the watchdog stall test.
*/
`timescale 1ns/1ps
`include "clk_ctrl_defines.svh"

module clock_source_pll_startup_tb;
   import clk_ctrl_pkg::*;

   // ------------------------------------------------------------------
   // Stimulus and observed signals
   // ------------------------------------------------------------------
   logic        clk_in = 1'b0;
   logic        rst_n_in = 1'b0;
   logic [3:0]  fuses = 4'h2;
   logic [1:0]  start_fuses = 2'h0;
   logic        div8_n = 1'b1;
   logic        rstdis_n = 1'b1;
   logic [7:0]  cal = 8'hA7;
   logic        por = 1'b0;
   logic        sleep = 1'b0;
   logic        wake = 1'b0;
   logic        src_tick = 1'b1;
   logic        wdt_tick = 1'b1;
   logic [3:0]  addr = 4'h0;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic        wreq;
   logic        pll_run, rc_run, half_ref, timer_ok, cpu_run, rsv;
   logic [7:0]  cal_out;
   logic [2:0]  src;
   logic [1:0]  div_log2;
   logic [31:0] got;
   int          errors = 0;
   int          checks_done = 0;

   clock_source_pll_startup i_clock_source_pll_startup
   (
      .clk_in(clk_in), .rst_n_in(rst_n_in),
      .clock_select_fuses_in(fuses), .startup_time_fuses_in(start_fuses),
      .divide_by_eight_fuse_n_in(div8_n),
      .reset_pin_disable_fuse_n_in(rstdis_n), .factory_cal_in(cal),
      .power_on_reset_in(por), .deep_sleep_in(sleep), .wake_in(wake),
      .src_tick_in(src_tick), .wdt_tick_in(wdt_tick),
      .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
      .avs_writedata_in(wdata), .avs_readdata_out(rdata),
      .avs_waitrequest_out(wreq), .pll_run_out(pll_run),
      .rc_osc_run_out(rc_run), .pll_half_ref_out(half_ref),
      .osc_calibration_out(cal_out), .sys_source_out(src),
      .sys_div_log2_out(div_log2), .fast_timer_clk_ok_out(timer_ok),
      .cpu_run_out(cpu_run), .reserved_setting_out(rsv)
   );

   // 20 MHz clock
   initial
   begin
      forever #25 clk_in = ~clk_in;
   end

   // ------------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------------
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : wrap_up

   task automatic chk(input string nm, input logic [31:0] exp,
                      input logic [31:0] seen);
      checks_done++;
      if (seen !== exp)
      begin
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
         errors++;
      end
   endtask : chk

   task automatic cycles(input int n);
      repeat (n) @(posedge clk_in);
   endtask : cycles

   // One bus cycle; read data taken at the edge where waitrequest is low
   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_in);
      addr  <= a;
      wdata <= d;
      rd    <= ~w;
      wr    <= w;
      do
      begin
         @(posedge clk_in);
         n++;
      end
      while (wreq !== 1'b0 && n < 50);
      got = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      if (n >= 50)
      begin
         $display("[ERR] bus wait expected answer seen none");
         errors++;
         wrap_up();
      end
   endtask : bus

   // Bounded wait for execution to be allowed
   task automatic wait_run(input int bound);
      int n;
      n = 0;
      while (cpu_run !== 1'b1 && n < bound)
      begin
         @(posedge clk_in);
         n++;
      end
      if (n >= bound)
      begin
         $display("[ERR] cpu_run expected 1 seen %b", cpu_run);
         errors++;
         wrap_up();
      end
   endtask : wait_run

   // Fuses only change while reset is held, as they are static
   task automatic restart(input logic [3:0] f, input logic [1:0] s,
                          input logic d8, input logic rd_n);
      @(posedge clk_in);
      rst_n_in <= 1'b0;
      fuses    <= f;
      start_fuses <= s;
      div8_n   <= d8;
      rstdis_n <= rd_n;
      cycles(16);
      chk("waitrequest in reset", 32'h1, 32'(wreq));
      chk("cpu_run in reset", 32'h0, 32'(cpu_run));
      rst_n_in <= 1'b1;
   endtask : restart

   // Cold start: still held at low_at, running within bound after that
   task automatic cold(input logic [3:0] f, input logic [1:0] s,
                       input logic rd_n, input int low_at, input int bound);
      restart(f, s, 1'b1, rd_n);
      cycles(low_at);
      chk("cpu_run early", 32'h0, 32'(cpu_run));
      wait_run(bound);
      chk("source", {28'h0, f}, 32'(src));
   endtask : cold

   // ------------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------------
   initial
   begin
      // Shipped default: RC 8 MHz, divide by eight programmed
      restart(4'h2, 2'h0, 1'b0, 1'b1);
      cycles(3);
      chk("cal_out", 32'hA7, 32'(cal_out));
      wait_run(60);
      chk("source", 32'h2, 32'(src));
      chk("div_log2", 32'h3, 32'(div_log2));
      bus(1'b0, `OFS_OSC_CAL, 32'h0);
      chk("cal reg", 32'hA7, got);
      bus(1'b1, `OFS_PLL_CSR, 32'h6);
      cycles(2);
      chk("half_ref", 32'h1, 32'(half_ref));
      chk("pll_run", 32'h0, 32'(pll_run));
      bus(1'b0, `OFS_STATUS, 32'h0);
      chk("status", 32'h22, got);
      bus(1'b1, 4'hC, 32'hFFFF_FFFF);
      bus(1'b0, 4'hC, 32'h0);
      chk("unmapped", 32'h0, got);
      bus(1'b1, `OFS_OSC_CAL, 32'h5A);
      bus(1'b0, `OFS_OSC_CAL, 32'h0);
      chk("cal write", 32'h5A, got);
      sleep <= 1'b1;
      cycles(5);
      chk("rc_run sleep", 32'h0, 32'(rc_run));
      chk("cpu_run sleep", 32'h0, 32'(cpu_run));
      sleep <= 1'b0;
      wake  <= 1'b1;
      @(posedge clk_in);
      wake  <= 1'b0;
      wait_run(40);
      $display("test rc8m done");

      // PLL source: cold start, then enable, lock, low-speed refusal
      cold(4'h1, 2'h0, 1'b1, 1300, 700);
      chk("pll div", 32'h2, 32'(div_log2));
      bus(1'b1, `OFS_PLL_CSR, 32'h2);
      cycles(80);
      chk("pll_run", 32'h1, 32'(pll_run));
      bus(1'b0, `OFS_PLL_CSR, 32'h0);
      chk("csr locked", 32'h3, got);
      chk("timer_ok", 32'h1, 32'(timer_ok));
      bus(1'b1, `OFS_PLL_CSR, 32'h6);
      bus(1'b0, `OFS_PLL_CSR, 32'h0);
      chk("csr low speed", 32'h3, got);
      chk("half_ref", 32'h0, 32'(half_ref));
      bus(1'b1, `OFS_OSC_CAL, 32'h40);
      bus(1'b0, `OFS_PLL_CSR, 32'h0);
      chk("csr after cal", 32'h2, got);
      sleep <= 1'b1;
      cycles(5);
      chk("pll_run sleep", 32'h0, 32'(pll_run));
      sleep <= 1'b0;
      wake  <= 1'b1;
      @(posedge clk_in);
      wake  <= 1'b0;
      cycles(1200);
      chk("cpu_run pll wake", 32'h0, 32'(cpu_run));
      wait_run(600);
      $display("test pll done");

      // Watchdog ticks alone time the reset delay
      restart(4'h2, 2'h1, 1'b1, 1'b1);
      cycles(100);
      wdt_tick <= 1'b0;
      cycles(800);
      chk("cpu_run wdt stalled", 32'h0, 32'(cpu_run));
      wdt_tick <= 1'b1;
      cycles(300);
      chk("cpu_run wdt part", 32'h0, 32'(cpu_run));
      wait_run(300);
      $display("test wdt done");

      // Reset-pin-disable stretches the shortest delay
      cold(4'h2, 2'h0, 1'b0, 300, 400);
      // 128 kHz: reserved setting stalls, normal setting runs
      restart(4'h3, 2'h3, 1'b1, 1'b1);
      cycles(50);
      chk("reserved", 32'h1, 32'(rsv));
      chk("cpu_run reserved", 32'h0, 32'(cpu_run));
      cold(4'h3, 2'h0, 1'b1, 5, 60);
      por <= 1'b1;
      @(posedge clk_in);
      por <= 1'b0;
      cycles(2);
      chk("cpu_run por", 32'h0, 32'(cpu_run));
      wait_run(60);
      // Watch crystal, shortest and longest settings
      cold(4'h4, 2'h0, 1'b1, 1400, 400);
      cold(4'h4, 2'h2, 1'b1, 40000, 2000);
      $display("test start-up table done");
      wrap_up();
   end
endmodule : clock_source_pll_startup_tb
